// >>> shared/atc_defs.vh
// Register offsets, field positions, reset values and timing counts of the acquisition/trigger control block
`ifndef ATC_DEFS_VH
`define ATC_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ATC_ADDR_W 16
`define ATC_OFF_ADC_SETUP 16'h809c
`define ATC_OFF_ACQ_CTRL 16'h8100
`define ATC_OFF_ACQ_STATUS 16'h8104
`define ATC_OFF_SW_TRIG 16'h8108
`define ATC_OFF_TRIG_SRC 16'h810c
`define ATC_OFF_TRIG_OUT 16'h8110
`define ATC_OFF_POST_TRIG 16'h8114
`define ATC_OFF_PANEL_IO 16'h8118
`define ATC_OFF_CHAN_CFG 16'h8000
`define ATC_OFF_EVT_LIMIT 16'h8200
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATC_ADC_CAL_BIT 1
`define ATC_ADC_PD_BIT 0
`define ATC_CTRL_CNT_ALL_BIT 3
`define ATC_CTRL_RUN_BIT 2
`define ATC_CTRL_MODE_HI 1
`define ATC_CTRL_MODE_LO 0
`define ATC_ST_READY_BIT 8
`define ATC_ST_PLL_BIT 7
`define ATC_ST_BYPASS_BIT 6
`define ATC_ST_EXTCLK_BIT 5
`define ATC_ST_FULL_BIT 4
`define ATC_ST_EVRDY_BIT 3
`define ATC_ST_RUN_BIT 2
`define ATC_MASK_SW_BIT 31
`define ATC_MASK_EXT_BIT 30
`define ATC_COINC_HI 26
`define ATC_COINC_LO 24
`define ATC_CFG_DES_BIT 12
// ----------------------------------------
// Run modes and reset values
// ----------------------------------------
`define ATC_MODE_REG 2'h0
`define ATC_MODE_SIN 2'h1
`define ATC_MODE_SYNC 2'h3
`define ATC_CTRL_RST 4'h0
`define ATC_MASK_RST 32'h00000000
`define ATC_POST_RST 32'h00000000
`define ATC_CFG_RST 13'h0010
`define ATC_EVT_LIMIT_RST 11'h400
// ----------------------------------------
// Post-trigger timing
// ----------------------------------------
`define ATC_LAT_EXT 32'h00000004
`define ATC_LAT_INT 32'h00000008
`define ATC_SAMPLES_PER_UNIT 16
`define ATC_SAMPLE_TOL 15
`endif

// >>> design/atc_acq_trig_ctrl.v
// Acquisition run control, trigger selection and status register bank on AXI4-Lite
// Notes on behaviour
// - Broadcast ADC write with calibration bit pulses calibration to all ADCs.
// - Control bit 3 chooses counting accepted triggers or all triggers.
// - Setting run bit in mode 00 enters run and pulses a memory reset.
// - Clearing run bit stops acquisition; stored data stay readable.
// - While stopped every trigger is ignored except at trigger output.
// - Run mode 00 register, 01 sync input, 11 sync only, 10 reserved.
// - Sync-input mode: sync input is sync and run start, gate always on.
// - Status bit 8 reads 1 only when PLL and ADCs synchronized.
// - Status bit 6 PLL bypass, bit 5 external clock source.
// - Status bit 4 set when stored events reach the maximum.
// - Status bit 3 set when at least one event is ready.
// - Any write to software trigger register makes one trigger.
// - Mask bit 30 enables external trigger, bit 31 software trigger.
// - Mask bits 7..0 let channel n make local trigger over threshold.
// - Local trigger needs coincidence level of other enabled channels over threshold.
// - Output mask picks channels, external and software triggers for trigger output.
// - Post samples are (value plus latency) times 16, doubled in dual edge.
// - Latency constant is 4 for external and 8 for internal triggers.
// - Panel register reads LVDS levels, writes levels of output lines.
// - Channel config bit 12 selects dual edge; even channels unused then.
`timescale 1ns/1ps
`default_nettype none
`include "atc_defs.vh"
module atc_acq_trig_ctrl (
  input wire ref_clk,
  input wire rst_b,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sync_in,
  input wire external_trigger_input,
  input wire [7:0] chan_over_thr,
  input wire pll_locked,
  input wire pll_bypass,
  input wire clk_src_ext,
  input wire adc_synced,
  input wire event_stored,
  input wire event_read,
  input wire [15:0] panel_io_in,
  output reg [15:0] panel_io_out,
  output reg trigger_output,
  output reg adc_calibrate,
  output reg adc_power_down,
  output reg memory_reset,
  output reg acq_running,
  output reg acq_gate,
  output reg acq_trigger,
  output reg acq_trigger_ext,
  output reg count_all_triggers,
  output reg dual_edge,
  output reg [31:0] post_trigger_sample_count
);
// ----------------------------------------
// Input synchronisers
// ----------------------------------------
  localparam NSYNC = 30;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] sync1_q;
  reg [NSYNC-1:0] sync2_q;
  assign async_in = {panel_io_in, sync_in, external_trigger_input, chan_over_thr,
                     pll_locked, pll_bypass, clk_src_ext, adc_synced};
  // Second stage only is read; first stage may be metastable
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= {NSYNC{1'b0}};
      sync2_q <= {NSYNC{1'b0}};
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end
  wire [15:0] pio_s = sync2_q[29:14];
  wire sin_s = sync2_q[13];
  wire ext_s = sync2_q[12];
  wire [7:0] thr_s = sync2_q[11:4];
  wire lock_s = sync2_q[3];
  wire byp_s = sync2_q[2];
  wire extclk_s = sync2_q[1];
  wire ready_s = sync2_q[0];
// ----------------------------------------
// AXI4-Lite slave
// ----------------------------------------
  reg aw_held_q;
  reg w_held_q;
  reg [15:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  function is_mapped;
    input [15:0] a;
    begin
      case (a)
        `ATC_OFF_ADC_SETUP, `ATC_OFF_ACQ_CTRL, `ATC_OFF_ACQ_STATUS, `ATC_OFF_SW_TRIG,
        `ATC_OFF_TRIG_SRC, `ATC_OFF_TRIG_OUT, `ATC_OFF_POST_TRIG, `ATC_OFF_PANEL_IO,
        `ATC_OFF_CHAN_CFG, `ATC_OFF_EVT_LIMIT: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction
  wire wr_ok = wr_fire && is_mapped(awaddr_q);
  wire wr_adc = wr_fire && awaddr_q == `ATC_OFF_ADC_SETUP;
  wire wr_ctrl = wr_fire && awaddr_q == `ATC_OFF_ACQ_CTRL;
  wire wr_swt = wr_fire && awaddr_q == `ATC_OFF_SW_TRIG;
  wire wr_src = wr_fire && awaddr_q == `ATC_OFF_TRIG_SRC;
  wire wr_out = wr_fire && awaddr_q == `ATC_OFF_TRIG_OUT;
  wire wr_post = wr_fire && awaddr_q == `ATC_OFF_POST_TRIG;
  wire wr_pio = wr_fire && awaddr_q == `ATC_OFF_PANEL_IO;
  wire wr_cfg = wr_fire && awaddr_q == `ATC_OFF_CHAN_CFG;
  wire wr_lim = wr_fire && awaddr_q == `ATC_OFF_EVT_LIMIT;
  wire rd_status = rd_fire && s_axi_araddr == `ATC_OFF_ACQ_STATUS;
// ----------------------------------------
// Registers
// ----------------------------------------
  reg [3:0] ctrl_q;
  reg [31:0] src_mask_q;
  reg [31:0] out_mask_q;
  reg [31:0] post_q;
  reg [12:0] cfg_q;
  reg [10:0] limit_q;
  reg [10:0] ev_cnt_q;
  reg pll_ok_q;
  reg run_q;
  reg run_prev_q;
  reg sin_prev_q;
  // Byte-lane merges of the held write data into the narrow registers
  wire [31:0] ctrl_m = merge({28'h0000000, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] pio_m = merge({16'h0000, panel_io_out}, wdata_q, wstrb_q);
  wire [1:0] mode = ctrl_q[`ATC_CTRL_MODE_HI:`ATC_CTRL_MODE_LO];
  wire sin_rise = sin_s && !sin_prev_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire [31:0] wd = merge(32'h00000000, wdata_q, wstrb_q);
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `ATC_CTRL_RST;
      src_mask_q <= `ATC_MASK_RST;
      out_mask_q <= `ATC_MASK_RST;
      post_q <= `ATC_POST_RST;
      cfg_q <= `ATC_CFG_RST;
      limit_q <= `ATC_EVT_LIMIT_RST;
      panel_io_out <= 16'h0000;
      adc_calibrate <= 1'b0;
      adc_power_down <= 1'b0;
    end else begin
      adc_calibrate <= wr_adc && wd[`ATC_ADC_CAL_BIT];
      if (wr_adc) adc_power_down <= wd[`ATC_ADC_PD_BIT];
      if (wr_ctrl) ctrl_q <= ctrl_m[3:0];
      if (wr_src) src_mask_q <= merge(src_mask_q, wdata_q, wstrb_q);
      if (wr_out) out_mask_q <= merge(out_mask_q, wdata_q, wstrb_q);
      if (wr_post) post_q <= merge(post_q, wdata_q, wstrb_q);
      if (wr_pio) panel_io_out <= pio_m[15:0];
      if (wr_cfg) cfg_q <= wd[12:0];
      if (wr_lim) limit_q <= wd[10:0];
    end
  end
// ----------------------------------------
// Run control
// ----------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      run_prev_q <= 1'b0;
      sin_prev_q <= 1'b0;
      acq_running <= 1'b0;
      acq_gate <= 1'b0;
      memory_reset <= 1'b0;
      count_all_triggers <= 1'b0;
      dual_edge <= 1'b0;
    end else begin
      sin_prev_q <= sin_s;
      run_prev_q <= run_q;
      case (mode)
        `ATC_MODE_REG: run_q <= ctrl_q[`ATC_CTRL_RUN_BIT];
        `ATC_MODE_SIN: run_q <= ctrl_q[`ATC_CTRL_RUN_BIT] && (run_q || sin_rise);
        default: run_q <= 1'b0;
      endcase
      memory_reset <= run_q && !run_prev_q;
      acq_running <= run_q;
      acq_gate <= mode == `ATC_MODE_REG || mode == `ATC_MODE_SIN;
      count_all_triggers <= ctrl_q[`ATC_CTRL_CNT_ALL_BIT];
      dual_edge <= cfg_q[`ATC_CFG_DES_BIT];
    end
  end
// ----------------------------------------
// Triggers
// ----------------------------------------
  function [3:0] popcount;
    input [7:0] v;
    integer i;
    begin
      popcount = 4'h0;
      for (i = 0; i < 8; i = i + 1) popcount = popcount + {3'h0, v[i]};
    end
  endfunction
  wire [7:0] en_over = thr_s & src_mask_q[7:0];
  wire [3:0] coinc = {1'b0, src_mask_q[`ATC_COINC_HI:`ATC_COINC_LO]};
  // Triggering channel plus coincidence level others must be over threshold
  wire local_trig = en_over != 8'h00 && popcount(en_over) > coinc;
  wire ext_trig = ext_s && src_mask_q[`ATC_MASK_EXT_BIT];
  wire sw_trig = wr_swt && src_mask_q[`ATC_MASK_SW_BIT];
  wire [31:0] lat = ext_trig ? `ATC_LAT_EXT : `ATC_LAT_INT;
  wire [31:0] ns_base = (post_q + lat) << 4;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acq_trigger <= 1'b0;
      acq_trigger_ext <= 1'b0;
      trigger_output <= 1'b0;
      post_trigger_sample_count <= 32'h00000000;
    end else begin
      acq_trigger <= run_q && (local_trig || ext_trig || sw_trig);
      acq_trigger_ext <= run_q && ext_trig;
      trigger_output <= (thr_s & out_mask_q[7:0]) != 8'h00 || (ext_s && out_mask_q[`ATC_MASK_EXT_BIT]) ||
        (wr_swt && out_mask_q[`ATC_MASK_SW_BIT]);
      post_trigger_sample_count <= cfg_q[`ATC_CFG_DES_BIT] ? ns_base << 1 : ns_base;
    end
  end
// ----------------------------------------
// Status and event count
// ----------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_ok_q <= 1'b1;
      ev_cnt_q <= 11'h000;
    end else begin
      // Unlock wins over the read restore
      if (!lock_s) pll_ok_q <= 1'b0;
      else if (rd_status) pll_ok_q <= 1'b1;
      if (memory_reset) ev_cnt_q <= 11'h000;
      else if (event_stored && !event_read && ev_cnt_q != limit_q) ev_cnt_q <= ev_cnt_q + 11'h001;
      else if (event_read && !event_stored && ev_cnt_q != 11'h000) ev_cnt_q <= ev_cnt_q - 11'h001;
    end
  end
  wire [31:0] status = {23'h000000, ready_s, pll_ok_q, byp_s, extclk_s,
    ev_cnt_q >= limit_q, ev_cnt_q != 11'h000, acq_running, 2'h0};
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h3;
      case (s_axi_araddr)
        `ATC_OFF_ACQ_CTRL: s_axi_rdata <= {28'h0000000, ctrl_q};
        `ATC_OFF_ACQ_STATUS: s_axi_rdata <= status;
        `ATC_OFF_TRIG_SRC: s_axi_rdata <= src_mask_q & 32'hc70000ff;
        `ATC_OFF_TRIG_OUT: s_axi_rdata <= out_mask_q & 32'hc00000ff;
        `ATC_OFF_POST_TRIG: s_axi_rdata <= post_q;
        `ATC_OFF_PANEL_IO: s_axi_rdata <= {16'h0000, pio_s};
        `ATC_OFF_CHAN_CFG: s_axi_rdata <= {19'h00000, cfg_q};
        `ATC_OFF_EVT_LIMIT: s_axi_rdata <= {21'h000000, limit_q};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // atc_acq_trig_ctrl
`default_nettype wire

// >>> tb/atc_acq_trig_ctrl_asserts.sv
// Concurrent checks on the ports of the acquisition/trigger control block
`timescale 1ns/1ps
`default_nettype none
module atc_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic adc_calibrate,
  input wire logic memory_reset,
  input wire logic acq_running,
  input wire logic acq_trigger,
  input wire logic trigger_output,
  input wire logic [31:0] post_trigger_sample_count
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_cal_pulse; adc_calibrate |=> !adc_calibrate; endproperty
  a_cal_pulse: assert property (p_cal_pulse)
    else $error("calibration pulse longer than one cycle");
  property p_mr_start; memory_reset |-> $rose(acq_running); endproperty
  a_mr_start: assert property (p_mr_start)
    else $error("memory reset without run start");
  property p_start_mr; $rose(acq_running) |-> memory_reset; endproperty
  a_start_mr: assert property (p_start_mr)
    else $error("run start without memory reset");
  property p_mr_pulse; memory_reset |=> !memory_reset; endproperty
  a_mr_pulse: assert property (p_mr_pulse)
    else $error("memory reset longer than one cycle");
  // One cycle of slack covers a trigger launched on the stopping edge
  property p_trig_run; acq_trigger |-> acq_running || $past(acq_running); endproperty
  a_trig_run: assert property (p_trig_run)
    else $error("trigger accepted while stopped");
  property p_post_gran; post_trigger_sample_count[3:0] == 4'h0; endproperty
  a_post_gran: assert property (p_post_gran)
    else $error("post trigger count not a multiple of sixteen");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold)
    else $error("read response dropped or changed");
  property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_refuse: assert property (p_refuse)
    else $error("write taken while response pending");
  c_cal: cover property (adc_calibrate);
  c_mr: cover property (memory_reset);
  c_trig: cover property (acq_trigger);
  c_tout: cover property (trigger_output);
endmodule // atc_chk
bind atc_acq_trig_ctrl atc_chk chk_u (.ref_clk, .rst_b, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .adc_calibrate,
  .memory_reset, .acq_running, .acq_trigger, .trigger_output, .post_trigger_sample_count);
`default_nettype wire

// >>> tb/atc_fp_model.sv
// Front panel sources: sync input, external trigger, channel discriminators, LVDS inputs
`timescale 1ns/1ps
`default_nettype none
module atc_fp_model (
  input wire logic ref_clk,
  input wire logic ext_req,
  input wire logic sync_req,
  input wire logic [7:0] chan_req,
  output logic sync_in,
  output logic external_trigger_input,
  output logic [7:0] chan_over_thr,
  output logic [15:0] panel_io_in
);
  // Levels change just after an edge, like real cabling would relative to this clock
  initial begin
    sync_in = 1'b0;
    external_trigger_input = 1'b0;
    chan_over_thr = 8'h00;
    panel_io_in = 16'h3c5a;
  end
  always @(posedge ref_clk) begin
    sync_in <= sync_req;
    external_trigger_input <= ext_req;
    chan_over_thr <= chan_req;
  end
endmodule // atc_fp_model
`default_nettype wire

// >>> tb/testbench.sv
// Register-level tests of the acquisition/trigger control block
`timescale 1ns/1ps
`default_nettype none
`include "atc_defs.vh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic pll_locked = 1, pll_bypass = 1, clk_src_ext = 0, adc_synced = 1, event_stored = 0, event_read = 0;
  logic ext_req = 0, sync_req = 0;
  logic [7:0] chan_req = 8'h0;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sync_in, external_trigger_input;
  wire trigger_output, adc_calibrate, adc_power_down, memory_reset, acq_running, acq_gate, acq_trigger;
  wire acq_trigger_ext, count_all_triggers, dual_edge;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, post_trigger_sample_count;
  wire [15:0] panel_io_in, panel_io_out;
  wire [7:0] chan_over_thr;
  int errors = 0, compares = 0, trig_cnt = 0, cal_cnt = 0, mr_cnt = 0, ext_cnt = 0, tout_cnt = 0, lat4_cnt = 0;
  always #50 ref_clk = ~ref_clk;
  atc_acq_trig_ctrl dut_u (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_in,
    .external_trigger_input, .chan_over_thr, .pll_locked, .pll_bypass, .clk_src_ext, .adc_synced,
    .event_stored, .event_read, .panel_io_in, .panel_io_out, .trigger_output, .adc_calibrate,
    .adc_power_down, .memory_reset, .acq_running, .acq_gate, .acq_trigger, .acq_trigger_ext,
    .count_all_triggers, .dual_edge, .post_trigger_sample_count);
  atc_fp_model fp_u (.ref_clk, .ext_req, .sync_req, .chan_req, .sync_in, .external_trigger_input,
    .chan_over_thr, .panel_io_in);
  // ----------------------------------------
  // Pulse counters
  // ----------------------------------------
  always @(posedge ref_clk) begin
    trig_cnt += (acq_trigger === 1'b1);
    cal_cnt += (adc_calibrate === 1'b1);
    mr_cnt += (memory_reset === 1'b1);
    ext_cnt += (acq_trigger_ext === 1'b1);
    tout_cnt += (trigger_output === 1'b1);
    lat4_cnt += (post_trigger_sample_count === 32'd224);
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Settles six cycles after the response so synchronised effects have landed
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid === 1'b1) && n < 40);
    if (n >= 40) errors++;
    s_axi_bready <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid === 1'b1) && n < 40);
    if (n >= 40) errors++;
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic print_verdict();
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    print_verdict();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`ATC_OFF_TRIG_SRC); chk("coinc_default", v, 32'h0);
    rd(16'h8300); chk("unmapped", {r, v[29:0]}, 32'hc0000000);
    wr(`ATC_OFF_ADC_SETUP, 32'h2); chk("cal", cal_cnt, 1);
    chk("pwr_down", adc_power_down, 0);
    wr(`ATC_OFF_SW_TRIG, 32'h0); chk("trig_stopped", trig_cnt, 0);
    wr(`ATC_OFF_ACQ_CTRL, 32'h4); chk("run", {mr_cnt[7:0], 7'h0, acq_running, acq_gate}, 32'h203);
    rd(`ATC_OFF_ACQ_STATUS); chk("st_run", v & 32'h4, 32'h4);
    wr(`ATC_OFF_SW_TRIG, 32'h0); chk("sw_masked", trig_cnt, 0);
    wr(`ATC_OFF_TRIG_SRC, 32'h80000000);
    wr(`ATC_OFF_SW_TRIG, 32'h0); chk("sw_trig", trig_cnt, 1);
    wr(`ATC_OFF_SW_TRIG, 32'hffffffff); chk("sw_trig2", trig_cnt, 2);
    wr(`ATC_OFF_TRIG_SRC, 32'h01000003);
    chan_req <= 8'h01; repeat (8) @(posedge ref_clk); chk("coinc_lo", trig_cnt, 2);
    chan_req <= 8'h03; repeat (8) @(posedge ref_clk); chk("coinc_hi", trig_cnt > 2, 1);
    chan_req <= 8'h00;
    wr(`ATC_OFF_POST_TRIG, 32'd10); chk("post_int", post_trigger_sample_count, 32'd288);
    wr(`ATC_OFF_TRIG_SRC, 32'h40000000);
    wr(`ATC_OFF_TRIG_OUT, 32'h40000000);
    ext_req <= 1'b1; repeat (8) @(posedge ref_clk);
    ext_req <= 1'b0; repeat (8) @(posedge ref_clk);
    chk("ext_out", {tout_cnt > 0, ext_cnt > 0, lat4_cnt > 0}, 3'h7);
    chk("post_back", post_trigger_sample_count, 32'd288);
    wr(`ATC_OFF_CHAN_CFG, 32'h1010); chk("des", dual_edge, 1);
    chk("des_post", post_trigger_sample_count, 32'h00000240);
    wr(`ATC_OFF_CHAN_CFG, 32'h10);
    wr(`ATC_OFF_ACQ_CTRL, 32'hc); chk("cnt_all", count_all_triggers, 1);
    wr(`ATC_OFF_PANEL_IO, 32'ha5c3); chk("panel_out", panel_io_out, 16'ha5c3);
    rd(`ATC_OFF_PANEL_IO); chk("panel_in", v & 32'hffff, 32'h3c5a);
    rd(`ATC_OFF_ACQ_STATUS); chk("st_clk", v & 32'h1e0, 32'h1c0);
    pll_locked <= 0; pll_bypass <= 0; clk_src_ext <= 1; adc_synced <= 0;
    repeat (4) @(posedge ref_clk);
    pll_locked <= 1; repeat (4) @(posedge ref_clk);
    rd(`ATC_OFF_ACQ_STATUS); chk("st_unlock", v & 32'h1e0, 32'h020);
    rd(`ATC_OFF_ACQ_STATUS); chk("st_relock", v & 32'h1e0, 32'h0a0);
    wr(`ATC_OFF_EVT_LIMIT, 32'h2);
    event_stored <= 1; @(posedge ref_clk); event_stored <= 0;
    repeat (4) @(posedge ref_clk);
    rd(`ATC_OFF_ACQ_STATUS); chk("ev_ready", v & 32'h18, 32'h08);
    event_stored <= 1; @(posedge ref_clk); event_stored <= 0;
    repeat (4) @(posedge ref_clk);
    rd(`ATC_OFF_ACQ_STATUS); chk("ev_full", v & 32'h18, 32'h18);
    wr(`ATC_OFF_TRIG_SRC, 32'h80000000);
    wr(`ATC_OFF_ACQ_CTRL, 32'h0); chk("stop", acq_running, 0);
    rd(`ATC_OFF_ACQ_STATUS); chk("st_stop", v & 32'h1c, 32'h18);
    v = trig_cnt;
    wr(`ATC_OFF_SW_TRIG, 32'h1); chk("stop_trig", trig_cnt, v);
    wr(`ATC_OFF_ACQ_CTRL, 32'h5); chk("sin_wait", acq_running, 0);
    v = mr_cnt;
    // Model flop, two sync flops, run flop, then output flop: leave margin past the counter edge
    sync_req <= 1'b1; repeat (8) @(posedge ref_clk);
    sync_req <= 1'b0;
    chk("sin_run", {acq_running, acq_gate, mr_cnt[7:0]}, {2'h3, v[7:0] + 8'h1});
    wr(`ATC_OFF_ACQ_CTRL, 32'h0);
    wr(`ATC_OFF_ACQ_CTRL, 32'h7); chk("sync_only", {acq_running, acq_gate}, 2'h0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
